// *** smb_pkg.sv ***
// Purpose: constants and types for the smbus host and slave controller
// Assumes: 250 MHz aclk, registers reached over axi4-lite
// Notes: register byte address is four times the register index
//
// Contract
// - software sets cycle kind, then or together sets start; one master cycle runs
// - low four control bits are ignored on writes while master is busy
// - parameter register writes while busy complete on the bus but store nothing
// - timeout while master: issue stop and set the timeout flag
// - master cycles start only in the full-on power state
// - slave side answers only word writes to own or snoop address (here any write to them is acknowledged, whatever its length)
// - snoop hit: command to capture low byte, data word to slave data
// - own hit: address to capture 7:1, or 15:1 for ten-bit addressing
// - hit flag set at stop after a match, or on timeout after match
// - while a hit flag is set, first acknowledge of a new access is withheld
// - slave side works except in mechanical off, raises interrupt and wake
// - receive-byte to alert address stores returned address in alert low byte
// - ten-bit prefix in returned address: read next byte into alert high byte
package smb_pkg;
  localparam int ADDR_W = 10;
  // ************************
  // register indexes
  // ************************
  localparam logic [7:0] IDX_STATUS = 8'hE0;
  localparam logic [7:0] IDX_CTRL = 8'hE2;
  localparam logic [7:0] IDX_PDATA = 8'hE4;
  localparam logic [7:0] IDX_ALERT = 8'hE6;
  localparam logic [7:0] IDX_PADDR = 8'hE8;
  localparam logic [7:0] IDX_PCMD = 8'hE9;
  localparam logic [7:0] IDX_SDATA = 8'hEA;
  localparam logic [7:0] IDX_SCAP = 8'hEC;
  localparam logic [7:0] IDX_OWN = 8'hEE;
  localparam logic [7:0] IDX_SNOOP = 8'hEF;
  localparam logic [7:0] IDX_IRQ_EN = 8'hF0;
  localparam logic [7:0] IDX_IRQ_CLR = 8'hF1;
  // ************************
  // fields
  // ************************
  localparam int NST = 6;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_TO = 2;
  localparam int ST_OWN = 3;
  localparam int ST_SNP = 4;
  localparam int ST_ALERT = 5;
  localparam logic [NST-1:0] ST_W1C = 6'h3E;
  localparam int CTL_START = 3;
  localparam int OWN_TEN = 15;
  localparam int SY_SCL = 0;
  localparam int SY_SDA = 1;
  localparam int SY_ALERT = 2;
  localparam int SY_FON = 3;
  localparam int SY_MECHANICAL_OFF_STATE = 4;
  localparam logic [2:0] K_QUICK = 3'h0;
  localparam logic [2:0] K_RECV = 3'h1;
  localparam logic [2:0] K_SEND = 3'h2;
  localparam logic [2:0] K_WBYTE = 3'h3;
  localparam logic [2:0] K_WWORD = 3'h4;
  localparam logic [6:0] ALERT_ADDR = 7'h0C;
  localparam logic [4:0] TEN_PREFIX = 5'h1E;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ************************
  // reset values and timing
  // ************************
  localparam logic [15:0] RST_OWN = 16'h0010;
  localparam logic [7:0] RST_SNOOP = 8'h00;
  localparam int CLK_NS = 4;
  localparam int QTR_NS = 2500;
  localparam int QTR_CYC = (QTR_NS + CLK_NS - 1) / CLK_NS;
  localparam int TIMEOUT_NS = 25000000;
  localparam int TIMEOUT_CYC = (TIMEOUT_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [1:0] {M_IDLE, M_START, M_BYTE, M_STOP} m_state_t;
  typedef enum logic [1:0] {S_IDLE, S_RX, S_ACK, S_WAIT} s_state_t;
endpackage : smb_pkg

// *** smb_ctrl.sv ***
// Purpose: smbus master engine, own/snoop slave capture, axi4-lite registers
// Assumes: scl, sda and power inputs are asynchronous and synchronised here
// Notes: master does not honour clock stretching; timeout recovers a stuck bus
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
module smb_ctrl #(
  parameter int TO_CYC = smb_pkg::TIMEOUT_CYC,
  parameter int Q_CYC = smb_pkg::QTR_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite register port
  input wire logic [smb_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [smb_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // smbus pins, enables low while pulling the wire low
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic alert_n,
  // system power state
  input wire logic full_on_state,
  input wire logic mechanical_off_state,
  // events
  output logic irq,
  output logic wake
);
  import smb_pkg::*;
  localparam int TO_W = 23;

  if (Q_CYC < 2 || Q_CYC > 1023) begin : g_chk_q
    $error("Q_CYC out of range");
  end
  if (TO_CYC < 2 || TO_CYC >= 2 ** TO_W) begin : g_chk_to
    $error("TO_CYC out of range");
  end

  typedef struct packed {
    logic [4:0] sy1;
    logic [4:0] sy2;
    logic scl_q;
    logic sda_q;
    logic aw_ok;
    logic [ADDR_W-1:0] awa;
    logic w_ok;
    logic [31:0] wd;
    logic [3:0] ws;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [2:0] kind;
    logic [7:0] p_addr;
    logic [7:0] p_cmd;
    logic [15:0] p_data;
    logic [15:0] alert_resp;
    logic [15:0] s_data;
    logic [15:0] s_cap;
    logic [15:0] own;
    logic [7:0] snp;
    logic [NST-1:0] status;
    logic [NST-1:0] ien;
    m_state_t ms;
    logic [9:0] mq;
    logic [1:0] mph;
    logic [3:0] mbit;
    logic [2:0] midx;
    logic [2:0] mlast;
    logic [7:0] msh;
    logic mrd;
    s_state_t ss;
    logic [3:0] sbit;
    logic [7:0] ssh;
    logic [2:0] sidx;
    logic [7:0] b0;
    logic s_ten;
    logic s_own;
    logic s_snp;
    logic s_drv;
    logic [TO_W-1:0] to_cnt;
    logic scl_oe_n;
    logic sda_oe_n;
    logic irq;
    logic wake;
  } st_t;

  st_t c;
  st_t n;
  logic scl, sda, scl_r, scl_f, start_ev, stop_ev;
  logic wf, busy, tick, to_hit, go, recv_alert, more_rd, full_on_s, mech_s;
  logic [7:0] widx;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  function automatic logic [7:0] tx_byte(input logic [2:0] idx, input st_t r);
    case (idx)
      3'h0: tx_byte = (r.kind == K_QUICK) ? r.p_addr : {r.p_addr[7:1], r.kind == K_RECV};
      3'h1: tx_byte = r.p_cmd;
      3'h2: tx_byte = r.p_data[7:0];
      default: tx_byte = r.p_data[15:8];
    endcase
  endfunction : tx_byte

  function automatic logic [2:0] last_idx(input logic [2:0] k);
    case (k)
      K_RECV, K_SEND: last_idx = 3'h1;
      K_WBYTE: last_idx = 3'h2;
      K_WWORD: last_idx = 3'h3;
      default: last_idx = 3'h0;
    endcase
  endfunction : last_idx

  assign scl = c.sy2[SY_SCL];
  assign sda = c.sy2[SY_SDA];
  assign full_on_s = c.sy2[SY_FON];
  assign mech_s = c.sy2[SY_MECHANICAL_OFF_STATE];
  assign scl_r = scl && !c.scl_q;
  assign scl_f = !scl && c.scl_q;
  assign start_ev = scl && c.scl_q && c.sda_q && !sda;
  assign stop_ev = scl && c.scl_q && !c.sda_q && sda;
  assign wf = c.aw_ok && c.w_ok && !c.bvalid;
  assign widx = c.awa[ADDR_W-1:2];
  assign busy = c.ms != M_IDLE;
  assign tick = c.mq == 10'(Q_CYC - 1);
  assign to_hit = c.to_cnt == TO_W'(TO_CYC);
  assign go = wf && widx == IDX_CTRL && c.ws[0] && c.wd[CTL_START] && !busy && full_on_s;
  assign recv_alert = c.kind == K_RECV && c.p_addr[7:1] == ALERT_ADDR;
  assign more_rd = recv_alert && c.midx == 3'h1 && c.msh[7:3] == TEN_PREFIX;

  always_comb begin
    logic [NST-1:0] ev;
    logic [NST-1:0] clr;
    logic [31:0] rd;
    logic rok;
    logic m_scl;
    logic m_sda;
    logic [2:0] j;
    n = c;
    ev = '0;
    clr = '0;
    rd = 32'h0000_0000;
    rok = 1'b1;
    m_scl = 1'b0;
    m_sda = 1'b0;
    j = c.sidx - {2'b00, c.s_ten};
    n.sy1 = {mechanical_off_state, full_on_state, alert_n, sda_in, scl_in};
    n.sy2 = c.sy1;
    n.scl_q = scl;
    n.sda_q = sda;
    // ************************
    // axi4-lite slave
    // ************************
    if (awvalid && c.awready) begin
      n.aw_ok = 1'b1;
      n.awa = awaddr;
    end
    if (wvalid && c.wready) begin
      n.w_ok = 1'b1;
      n.wd = wdata;
      n.ws = wstrb;
    end
    if (c.bvalid && bready) n.bvalid = 1'b0;
    if (wf) begin
      n.aw_ok = 1'b0;
      n.w_ok = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OK;
      case (widx)
        IDX_STATUS, IDX_IRQ_CLR: if (c.ws[0]) clr = c.wd[NST-1:0] & ST_W1C;
        IDX_CTRL: if (c.ws[0] && !busy) n.kind = c.wd[2:0];
        IDX_PDATA: if (!busy) n.p_data = merge16(c.p_data, c.wd, c.ws);
        IDX_PADDR: if (!busy && c.ws[0]) n.p_addr = c.wd[7:0];
        IDX_PCMD: if (!busy && c.ws[0]) n.p_cmd = c.wd[7:0];
        IDX_OWN: n.own = merge16(c.own, c.wd, c.ws);
        IDX_SNOOP: if (c.ws[0]) n.snp = c.wd[7:0];
        IDX_IRQ_EN: if (c.ws[0]) n.ien = c.wd[NST-1:0] & ST_W1C;
        IDX_ALERT, IDX_SDATA, IDX_SCAP: ;
        default: n.bresp = RESP_SLVERR;
      endcase
    end
    case (araddr[ADDR_W-1:2])
      IDX_STATUS: rd = {26'h0, c.status[NST-1:1], busy};
      IDX_CTRL: rd = {29'h0, c.kind};
      IDX_PDATA: rd = {16'h0, c.p_data};
      IDX_ALERT: rd = {16'h0, c.alert_resp};
      IDX_PADDR: rd = {24'h0, c.p_addr};
      IDX_PCMD: rd = {24'h0, c.p_cmd};
      IDX_SDATA: rd = {16'h0, c.s_data};
      IDX_SCAP: rd = {16'h0, c.s_cap};
      IDX_OWN: rd = {16'h0, c.own};
      IDX_SNOOP: rd = {24'h0, c.snp};
      IDX_IRQ_EN: rd = {26'h0, c.ien};
      IDX_IRQ_CLR: ;
      default: rok = 1'b0;
    endcase
    if (c.rvalid && rready) n.rvalid = 1'b0;
    if (arvalid && c.arready) begin
      n.rvalid = 1'b1;
      n.rdata = rd;
      n.rresp = rok ? RESP_OK : RESP_SLVERR;
    end
    n.arready = !n.rvalid;
    n.awready = !n.aw_ok;
    n.wready = !n.w_ok;
    // ************************
    // bus timeout, scl held low
    // ************************
    if (scl) n.to_cnt = '0;
    else if (!to_hit) n.to_cnt = c.to_cnt + TO_W'(1);
    // ************************
    // master engine
    // ************************
    if (busy) begin
      n.mq = tick ? 10'h000 : c.mq + 10'h001;
      if (tick) n.mph = c.mph + 2'h1;
    end
    case (c.ms)
      M_IDLE: if (go) begin
        n.ms = M_START;
        n.mq = 10'h000;
        n.mph = 2'h0;
        n.midx = 3'h0;
        n.mbit = 4'h0;
        n.mrd = 1'b0;
        n.mlast = last_idx(c.wd[2:0]);
      end
      M_START: if (tick && c.mph == 2'h2) begin
        n.ms = M_BYTE;
        n.mph = 2'h0;
        n.msh = tx_byte(3'h0, c);
      end
      M_BYTE: begin
        if (tick && c.mph == 2'h2) begin
          if (c.mrd && c.mbit != 4'h8) n.msh = {c.msh[6:0], sda};
          // a refused byte ends the cycle early
          if (!c.mrd && c.mbit == 4'h8 && sda) n.mlast = c.midx;
        end
        if (tick && c.mph == 2'h3) begin
          n.mbit = c.mbit + 4'h1;
          if (!c.mrd && c.mbit != 4'h8) n.msh = {c.msh[6:0], 1'b0};
          if (c.mbit == 4'h8) begin
            n.mbit = 4'h0;
            if (c.mrd && recv_alert && c.midx == 3'h1) n.alert_resp[7:0] = c.msh;
            else if (c.mrd && recv_alert) n.alert_resp[15:8] = c.msh;
            else if (c.mrd) n.p_data[7:0] = c.msh;
            if (more_rd) n.mlast = 3'h2;
            if (c.midx == n.mlast) n.ms = M_STOP;
            else begin
              n.midx = c.midx + 3'h1;
              n.msh = tx_byte(c.midx + 3'h1, c);
              n.mrd = c.kind == K_RECV;
            end
          end
        end
      end
      M_STOP: if (tick && c.mph == 2'h3) begin
        n.ms = M_IDLE;
        ev[ST_DONE] = 1'b1;
      end
      default: n.ms = M_IDLE;
    endcase
    if (to_hit && (c.ms == M_START || c.ms == M_BYTE)) begin
      n.ms = M_STOP;
      n.mq = 10'h000;
      n.mph = 2'h0;
      ev[ST_TO] = 1'b1;
    end
    case (n.ms)
      M_START: begin
        m_sda = n.mph != 2'h0;
        m_scl = n.mph == 2'h2;
      end
      M_BYTE: begin
        m_scl = n.mph == 2'h0 || n.mph == 2'h3;
        if (n.mbit == 4'h8) m_sda = n.mrd && more_rd;
        else m_sda = !n.mrd && !n.msh[7];
      end
      M_STOP: begin
        m_scl = n.mph == 2'h0;
        m_sda = n.mph < 2'h2;
      end
      default: ;
    endcase
    // ************************
    // slave capture engine
    // ************************
    // our own master traffic must not be parsed as a foreign access
    if (busy || mech_s) begin
      n.ss = S_IDLE;
      n.s_drv = 1'b0;
      n.s_own = 1'b0;
      n.s_snp = 1'b0;
    end else if (start_ev) begin
      n.ss = S_RX;
      n.sbit = 4'h0;
      n.sidx = 3'h0;
      n.s_own = 1'b0;
      n.s_snp = 1'b0;
      n.s_ten = 1'b0;
      n.s_drv = 1'b0;
    end else if (stop_ev || (to_hit && c.ss != S_IDLE)) begin
      n.ss = S_IDLE;
      n.s_drv = 1'b0;
      ev[ST_OWN] = c.s_own;
      ev[ST_SNP] = c.s_snp;
    end else begin
      case (c.ss)
        S_RX: if (scl_r) begin
          n.ssh = {c.ssh[6:0], sda};
          n.sbit = c.sbit + 4'h1;
        end else if (scl_f && c.sbit == 4'h8) begin
          n.ss = S_ACK;
          n.s_drv = 1'b1;
          if (c.sidx == 3'h0) begin
            n.b0 = c.ssh;
            n.s_snp = !c.ssh[0] && c.ssh[7:1] == c.snp[7:1];
            n.s_own = !c.ssh[0] && !c.own[OWN_TEN] && c.ssh[7:1] == c.own[7:1];
            n.s_ten = !c.ssh[0] && c.own[OWN_TEN] && c.ssh[7:3] == TEN_PREFIX
                      && c.ssh[2:1] == c.own[10:9];
            if (!(n.s_snp || n.s_own || n.s_ten) || c.status[ST_OWN] || c.status[ST_SNP]) begin
              n.ss = S_WAIT;
              n.s_drv = 1'b0;
              n.s_own = 1'b0;
              n.s_snp = 1'b0;
            end else if (n.s_own) n.s_cap = {8'h00, c.ssh[7:1], 1'b0};
          end else if (c.s_ten && c.sidx == 3'h1) begin
            if (c.ssh == c.own[8:1]) begin
              n.s_own = 1'b1;
              n.s_cap = {c.b0[7:1], c.ssh, 1'b0};
            end else begin
              n.ss = S_WAIT;
              n.s_drv = 1'b0;
            end
          end else if (j == 3'h1 && c.s_snp) n.s_cap = {8'h00, c.ssh};
          else if (j == 3'h2) n.s_data[7:0] = c.ssh;
          else if (j == 3'h3) n.s_data[15:8] = c.ssh;
        end
        S_ACK: if (scl_f) begin
          n.ss = S_RX;
          n.s_drv = 1'b0;
          n.sbit = 4'h0;
          if (c.sidx != 3'h7) n.sidx = c.sidx + 3'h1;
        end
        default: ;
      endcase
    end
    ev[ST_ALERT] = !c.sy2[SY_ALERT];
    // set wins over a clear in the same cycle
    n.status = (c.status & ~clr) | ev;
    n.scl_oe_n = !m_scl;
    n.sda_oe_n = !(m_sda || n.s_drv);
    n.irq = |(n.status & n.ien);
    n.wake = |(n.status[ST_SNP:ST_OWN] & n.ien[ST_SNP:ST_OWN]);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      c <= '0;
      c.own <= RST_OWN;
      c.snp <= RST_SNOOP;
      c.scl_oe_n <= 1'b1;
      c.sda_oe_n <= 1'b1;
      c.sy1 <= 5'h07;
      c.sy2 <= 5'h07;
      c.scl_q <= 1'b1;
      c.sda_q <= 1'b1;
    end else begin
      c <= n;
    end
  end

  assign awready = c.awready;
  assign wready = c.wready;
  assign bvalid = c.bvalid;
  assign bresp = c.bresp;
  assign arready = c.arready;
  assign rvalid = c.rvalid;
  assign rdata = c.rdata;
  assign rresp = c.rresp;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_n = c.scl_oe_n;
  assign sda_oe_n = c.sda_oe_n;
  assign irq = c.irq;
  assign wake = c.wake;

  // ************************
  // checks
  // ************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_busy_ctrl_hold: assert property ((wf && widx == IDX_CTRL && busy) |=> $stable(c.kind))
    else $error("control written while busy");
  a_busy_param_hold: assert property ((wf && busy) |=> ($stable(c.p_addr) && $stable(c.p_cmd)))
    else $error("parameter written while busy");
  a_timeout_stop: assert property ((to_hit && (c.ms == M_START || c.ms == M_BYTE))
    |=> (c.ms == M_STOP && c.status[ST_TO]))
    else $error("timeout did not force stop");
  a_no_start_off: assert property ((!busy && !full_on_s) |=> !busy)
    else $error("master started outside full on");
  a_hit_on_stop: assert property ((stop_ev && c.s_snp && !busy && !mech_s && !start_ev)
    |=> c.status[ST_SNP])
    else $error("snoop hit not flagged at stop");
  a_ack_withheld: assert property ((c.ss == S_RX && scl_f && c.sbit == 4'h8 && c.sidx == 3'h0
    && (c.status[ST_OWN] || c.status[ST_SNP]) && !busy && !mech_s && !start_ev && !stop_ev
    && !to_hit) |=> (c.ss == S_WAIT && c.sda_oe_n))
    else $error("access acknowledged while hit flag set");
  a_off_quiet: assert property (mech_s |=> (c.ss == S_IDLE && !c.s_drv))
    else $error("slave active in mechanical off");
  a_alert_store: assert property ((c.ms == M_BYTE && tick && c.mph == 2'h3 && c.mbit == 4'h8
    && c.mrd && recv_alert && c.midx == 3'h1) |=> c.alert_resp[7:0] == $past(c.msh))
    else $error("alert address not stored");
  a_stop_idle: assert property ((c.ms == M_STOP && tick && c.mph == 2'h3)
    |=> (!busy && c.status[ST_DONE]))
    else $error("busy did not fall after stop");
endmodule : smb_ctrl

// *** smb_partner.sv ***
// Purpose: far-side smbus parties, one target slave and one bus master
// Assumes: both wires pulled up; a released line is driven 1 here
// Notes: master bit period 32 ns, no arbitration, idle clock stands still
`timescale 1ns/10ps
module smb_partner (
  // wire levels
  input wire logic scl,
  input wire logic sda,
  output logic scl_rel,
  output logic sda_rel,
  // bench control
  input wire logic [6:0] dev,
  input wire logic [15:0] rd_bytes,
  input wire logic stretch
);
  logic ms_scl = 1'b1;
  logic ms_sda = 1'b1;
  logic sl_sda = 1'b1;
  logic [7:0] sh;
  logic [7:0] got [4];
  logic hit;
  logic rd;
  logic ack;
  logic tx;
  int nb;
  int frames = 0;
  // stretch holds scl low, only when the bench asks for a stuck bus
  assign scl_rel = ms_scl & ~stretch;
  assign sda_rel = ms_sda & sl_sda;
  // ****************
  // target slave
  // ****************
  always @(posedge sda) if (scl === 1'b1) disable slv;
  always begin : slv
    sl_sda = 1'b1;
    tx = 1'b0;
    // the count survives the stop so the bench can read it afterwards
    @(negedge sda iff scl === 1'b1);
    nb = 0;
    forever begin
      for (int i = 7; i >= 0; i--) begin
        if (tx) sl_sda = (nb == 1) ? rd_bytes[i] : rd_bytes[8+i];
        @(posedge scl);
        sh[i] = sda;
        @(negedge scl);
      end
      sl_sda = 1'b1;
      if (nb == 0) begin
        hit = (sh[7:1] == dev);
        rd = sh[0];
        frames += int'(hit);
      end
      if (hit && !tx) sl_sda = 1'b0;
      if (nb < 4) got[nb] = sh;
      @(posedge scl);
      ack = ~sda;
      @(negedge scl);
      sl_sda = 1'b1;
      // keep sending only while the master acknowledges
      tx = hit & rd & ack;
      nb++;
    end
  end
  // ****************
  // bus master
  // ****************
  task automatic send(input logic [31:0] b, output logic [3:0] acks);
    // keep every wire edge off the sampling clock edge
    #1;
    ms_sda = 1'b0;
    #16 ms_scl = 1'b0;
    #12;
    for (int k = 3; k >= 0; k--) begin
      for (int i = 8; i >= 0; i--) begin
        ms_sda = (i > 0) ? b[8*k+i-1] : 1'b1;
        #4 ms_scl = 1'b1;
        #8 acks[k] = ~sda;
        #8 ms_scl = 1'b0;
        #12;
      end
    end
    ms_sda = 1'b0;
    #4 ms_scl = 1'b1;
    #12 ms_sda = 1'b1;
    #16;
  endtask : send
endmodule : smb_partner

// *** smb_ctrl_tb.sv ***
// Purpose: self-checking bench for the smbus controller
// Assumes: 4 ns aclk, shortened timeout and quarter counts
// Notes: the partner target slave answers at address 50h
`timescale 1ns/10ps
module smb_ctrl_tb;
  import smb_pkg::*;
  localparam logic [6:0] TGT = 7'h50;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic alert_n = 1'b1;
  logic full_on_state = 1'b1;
  logic mechanical_off_state = 1'b0;
  logic [6:0] dev = TGT;
  logic [15:0] rd_bytes = 16'h5AF2;
  logic stretch = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, wake;
  logic scl_oe_n, sda_oe_n, scl_out, sda_out, p_scl, p_sda;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int err_total = 0;
  int checked = 0;
  wire scl = (scl_oe_n | scl_out) & p_scl;
  wire sda = (sda_oe_n | sda_out) & p_sda;
  smb_ctrl #(.TO_CYC(100), .Q_CYC(4)) DUT (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .scl_in(scl), .scl_out, .scl_oe_n, .sda_in(sda), .sda_out, .sda_oe_n,
    .alert_n, .full_on_state, .mechanical_off_state, .irq, .wake
  );
  smb_partner pm (
    .scl, .sda, .scl_rel(p_scl), .sda_rel(p_sda), .dev, .rd_bytes, .stretch
  );
  initial begin
    forever #2 aclk = ~aclk;
  end
  // ****************
  // access tasks
  // ****************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] i, input logic [31:0] d, input logic [1:0] er = RESP_OK);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= {i, 2'b00};
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 500);
    bready <= 1'b0;
    chk("bvalid", 1, bvalid);
    chk("bresp", er, bresp);
  endtask : wr
  task automatic rd(input logic [7:0] i, output logic [31:0] d, input logic [1:0] er = RESP_OK);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 500);
    rready <= 1'b0;
    d = rdata;
    chk("rvalid", 1, rvalid);
    chk("rresp", er, rresp);
  endtask : rd
  task automatic rchk(input logic [7:0] i, input logic [31:0] e, input logic [31:0] m = '1);
    logic [31:0] d;
    rd(i, d);
    chk($sformatf("reg %h", i), e, d & m);
  endtask : rchk
  // registered outputs change on the same edge as the write response; the check waits three cycles
  task automatic pchk(input string n, input logic e, ref logic g);
    repeat (3) @(posedge aclk);
    chk(n, e, g);
  endtask : pchk
  task automatic wait_idle();
    logic [31:0] d;
    int n;
    n = 0;
    do begin
      rd(IDX_STATUS, d);
      n++;
    end while (d[ST_BUSY] !== 1'b0 && n < 2000);
    chk("idle", 0, d[ST_BUSY]);
  endtask : wait_idle
  task automatic summarize();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  // ****************
  // tests
  // ****************
  initial begin : main
    logic [31:0] d;
    logic [3:0] a;
    static logic [15:0] alr [2] = '{16'h5AF2, 16'h5A42};
    static logic [31:0] bad [3] = '{32'h11770102, 32'h56770102, 32'h10770102};
    static int nbytes [5] = '{1, 2, 2, 3, 4};
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    rchk(IDX_OWN, {16'h0, RST_OWN});
    rchk(IDX_SNOOP, {24'h0, RST_SNOOP});
    rchk(IDX_STATUS, 32'h0);
    rd(8'h10, d, RESP_SLVERR);
    chk("unmapped", 32'h0, d);
    wr(8'h10, 32'h1, RESP_SLVERR);
    wr(IDX_IRQ_EN, 32'h3E);
    wr(IDX_PADDR, {24'h0, TGT, 1'b0});
    wr(IDX_PCMD, 32'h5C);
    wr(IDX_PDATA, 32'hB7A3);
    for (int k = 0; k < 5; k++) begin
      wr(IDX_CTRL, {28'h0, 1'b1, 3'(k)});
      rchk(IDX_STATUS, 32'h1, 32'h1);
      if (k == 2) begin
        wr(IDX_PCMD, 32'hEE);
        wr(IDX_PDATA, 32'h1111);
        wr(IDX_CTRL, 32'h0B);
        rchk(IDX_CTRL, 32'h2);
      end
      wait_idle();
      chk("bytes", nbytes[k], pm.nb);
    end
    chk("frames", 5, pm.frames);
    chk("cmd", 8'h5C, pm.got[1]);
    chk("data", 16'hB7F2, {pm.got[3], pm.got[2]});
    rchk(IDX_STATUS, 32'h2, 32'h3);
    pchk("irq", 1, irq);
    wr(IDX_IRQ_EN, 32'h0);
    pchk("irq", 0, irq);
    wr(IDX_IRQ_EN, 32'h3E);
    wr(IDX_STATUS, 32'h0);
    rchk(IDX_STATUS, 32'h2, 32'h2);
    wr(IDX_STATUS, 32'h2);
    rchk(IDX_STATUS, 32'h0, 32'h2);
    pchk("irq", 0, irq);
    dev <= ALERT_ADDR;
    alert_n <= 1'b0;
    wr(IDX_PADDR, {24'h0, ALERT_ADDR, 1'b1});
    for (int j = 0; j < 2; j++) begin
      rd_bytes <= alr[j];
      wr(IDX_CTRL, {28'h0, 1'b1, K_RECV});
      wait_idle();
      rchk(IDX_ALERT, {16'h0, alr[j]} & (j ? 32'hFF : 32'hFFFF),
           j ? 32'hFF : 32'hFFFF);
      chk("bytes", 3 - j, pm.nb);
    end
    rchk(IDX_STATUS, 32'h20, 32'h20);
    alert_n <= 1'b1;
    dev <= TGT;
    wr(IDX_PADDR, {24'h0, TGT, 1'b0});
    stretch <= 1'b1;
    wr(IDX_CTRL, {28'h0, 1'b1, K_SEND});
    wait_idle();
    rchk(IDX_STATUS, 32'h4, 32'h5);
    pchk("irq", 1, irq);
    stretch <= 1'b0;
    repeat (8) @(posedge aclk);
    chk("bus idle", 2'b11, {scl, sda});
    wr(IDX_IRQ_CLR, 32'h3E);
    rchk(IDX_STATUS, 32'h0, 32'h3E);
    full_on_state <= 1'b0;
    wr(IDX_CTRL, {28'h0, 1'b1, K_SEND});
    rchk(IDX_STATUS, 32'h0, 32'h1);
    wr(IDX_SNOOP, 32'h74);
    pm.send(32'h74C13412, a);
    chk("acks", 4'hF, a);
    rchk(IDX_SCAP, 32'hC1, 32'hFF);
    rchk(IDX_SDATA, 32'h1234, 32'hFFFF);
    rchk(IDX_STATUS, 32'h10, 32'h18);
    pchk("wake", 1, wake);
    pm.send(32'h74C13412, a);
    chk("acks", 4'h0, a);
    wr(IDX_STATUS, 32'h10);
    pm.send(32'h10770102, a);
    chk("acks", 4'hF, a);
    rchk(IDX_SCAP, 32'h10, 32'hFE);
    rchk(IDX_SDATA, 32'h0201, 32'hFFFF);
    rchk(IDX_STATUS, 32'h08, 32'h18);
    wr(IDX_STATUS, 32'h08);
    // ten-bit own address 123h
    wr(IDX_OWN, 32'h8246);
    pm.send(32'hF2235566, a);
    chk("acks", 4'hF, a);
    rchk(IDX_SCAP, 32'hF246, 32'hFFFE);
    wr(IDX_STATUS, 32'h08);
    wr(IDX_OWN, {16'h0, RST_OWN});
    for (int j = 0; j < 3; j++) begin
      @(posedge aclk) mechanical_off_state <= (j == 2);
      repeat (4) @(posedge aclk);
      pm.send(bad[j], a);
      chk("refused", 4'h0, a);
    end
    rchk(IDX_STATUS, 32'h0, 32'h18);
    summarize();
  end
  initial begin
    #300000;
    err_total++;
    summarize();
  end
endmodule : smb_ctrl_tb
